// ===== logic/pls_host.sv
// module: host end that shifts words and runs programming sequences
`timescale 1ns/1ps
`default_nettype none
module pls_host (
  pls_link_if.host                     link_io,
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic                    start_in,
  input  wire pls_pkg::pls_method_type method_in,
  input  wire logic [pls_pkg::WORD_W-1:0] func_word_in,
  input  wire logic [pls_pkg::WORD_W-1:0] ref_word_in,
  input  wire logic [pls_pkg::WORD_W-1:0] fb_word_in,
  input  wire logic                    ce_in,
  output logic                         busy_out,
  output logic                         done_out,
  output logic                         monitor_out
);
  import pls_pkg::*;

  pls_state_type        state_r;
  pls_method_type       meth_r;
  logic [1:0]           step_r;
  logic [XFER_BITS-1:0] sh_r;
  logic [4:0]           bit_cnt_r;
  logic [3:0]           wait_r;
  logic                 sclk_r;
  logic                 sdata_r;
  logic                 strobe_r;
  logic                 ce_r;
  logic                 busy_r;
  logic                 done_r;
  logic                 mon_s;

  // monitor pin comes from the other end's clock
  pls_sync2 u_mon_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .d_in       (link_io.monitor_output),
    .q_out      (mon_s)
  );

  // ----------------------------------------------------------------
  // word for each step of each method
  // ----------------------------------------------------------------
  wire [WORD_W-1:0] w_init  = {func_word_in[WORD_W-1:3], 1'b0, SEL_INIT};
  wire [WORD_W-1:0] w_func  = {func_word_in[WORD_W-1:2], SEL_FUNC};
  wire [WORD_W-1:0] w_hset  = {func_word_in[WORD_W-1:3], 1'b1, SEL_FUNC};
  wire [WORD_W-1:0] w_hclr  = {func_word_in[WORD_W-1:3], 1'b0, SEL_FUNC};
  wire [WORD_W-1:0] w_ref   = {ref_word_in[WORD_W-1:2], SEL_REF};
  wire [WORD_W-1:0] w_fb    = {fb_word_in[WORD_W-1:2], SEL_FB};
  // init: hold cleared init, ref, fb; pin: func, ref, fb;
  // hold: func with hold set, ref, fb, func with hold cleared
  wire [WORD_W-1:0] w_first = (meth_r == METH_INIT)   ? w_init :
                              (meth_r == METH_PIN)    ? w_func :
                              (meth_r == METH_HOLD)   ? w_hset :
                                                        func_word_in;
  wire [WORD_W-1:0] word    = (step_r == 2'h0) ? w_first :
                              (step_r == 2'h1) ? w_ref   :
                              (step_r == 2'h2) ? w_fb    :
                                                 w_hclr;
  wire [1:0]        last    = (meth_r == METH_SINGLE) ? 2'h0 :
                              (meth_r == METH_HOLD)   ? 2'h3 :
                                                        2'h2;
  wire              tick    = (wait_r == 4'h0);

  // ----------------------------------------------------------------
  // sequencer, shifter and serial clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_r   <= ST_IDLE;
      meth_r    <= METH_SINGLE;
      step_r    <= 2'h0;
      sh_r      <= 24'h000000;
      bit_cnt_r <= 5'h00;
      wait_r    <= 4'h0;
      sclk_r    <= 1'b0;
      sdata_r   <= 1'b0;
      strobe_r  <= 1'b0;
      ce_r      <= 1'b0;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          ce_r <= ce_in;
          if (start_in)
          begin
            meth_r  <= method_in;
            step_r  <= 2'h0;
            busy_r  <= 1'b1;
            state_r <= ST_LOAD;
            if (method_in == METH_PIN)
              ce_r <= 1'b0;
          end
        end
        ST_LOAD:
        begin
          // strobe low first; three pad bits lead the word
          strobe_r  <= 1'b0;
          sh_r      <= {{PAD_BITS{1'b0}}, word} << 1;
          sdata_r   <= 1'b0;
          bit_cnt_r <= 5'(XFER_BITS - 1);
          wait_r    <= 4'(SCLK_HALF_CYC - 1);
          state_r   <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          // data changes with the falling edge, sampled on the rise
          if (tick)
          begin
            wait_r <= 4'(SCLK_HALF_CYC - 1);
            sclk_r <= ~sclk_r;
            if (sclk_r)
            begin
              if (bit_cnt_r == 5'h00)
              begin
                wait_r  <= 4'(STROBE_HIGH_CYC - 1);
                state_r <= ST_STROBE;
              end
              else
              begin
                sdata_r   <= sh_r[XFER_BITS-1];
                sh_r      <= sh_r << 1;
                bit_cnt_r <= bit_cnt_r - 5'h01;
              end
            end
          end
          else
            wait_r <= wait_r - 4'h1;
        end
        ST_STROBE:
        begin
          // strobe after the last bit, held long enough to be seen
          strobe_r <= 1'b1;
          if (tick)
          begin
            if (step_r == last)
              state_r <= ST_DONE;
            else
            begin
              step_r  <= step_r + 2'h1;
              state_r <= ST_LOAD;
            end
          end
          else
            wait_r <= wait_r - 4'h1;
        end
        ST_DONE:
        begin
          if (meth_r == METH_PIN)
            ce_r <= 1'b1;
          busy_r  <= 1'b0;
          done_r  <= 1'b1;
          state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link_io.sclk         = sclk_r;
  assign link_io.sdata        = sdata_r;
  assign link_io.latch_strobe = strobe_r;
  assign link_io.chip_enable  = ce_r;
  assign busy_out             = busy_r;
  assign done_out             = done_r;
  assign monitor_out          = mon_s;
endmodule
`default_nettype wire

// ===== inc/pls_pkg.sv
// package: constants and types for the synthesizer serial load link
package pls_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int             WORD_W    = 21;
  localparam int             XFER_BITS = 24;
  localparam int             PAD_BITS  = XFER_BITS - WORD_W;
  localparam logic [1:0]     SEL_REF   = 2'h0;
  localparam logic [1:0]     SEL_FB    = 2'h1;
  localparam logic [1:0]     SEL_FUNC  = 2'h2;
  localparam logic [1:0]     SEL_INIT  = 2'h3;
  localparam int             HOLD_BIT  = 2;
  localparam int             PD1_BIT   = 3;
  localparam int             MUX_LSB   = 4;
  localparam int             CP3S_BIT  = 8;
  localparam int             PD2_BIT   = 19;
  localparam logic [20:0]    LATCH_RST = 21'h000000;

  // ----------------------------------------------------------------
  // monitor output selections
  // ----------------------------------------------------------------
  localparam logic [2:0]     MON_LOW    = 3'h0;
  localparam logic [2:0]     MON_LOCK   = 3'h1;
  localparam logic [2:0]     MON_HOLD   = 3'h2;
  localparam logic [2:0]     MON_PD     = 3'h3;
  localparam logic [2:0]     MON_ACTIVE = 3'h4;
  localparam logic [2:0]     MON_HIGH   = 3'h7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int             CLK_HZ        = 25_000_000;
  localparam int             SCLK_MAX_HZ   = 20_000_000;
  // least half period of the serial clock, rounded up to whole cycles
  localparam int             SCLK_HALF_CYC =
    (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  // strobe high time; the device needs three of its cycles to see it
  localparam int             STROBE_HIGH_CYC = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    METH_INIT   = 2'h0,
    METH_PIN    = 2'h1,
    METH_HOLD   = 2'h2,
    METH_SINGLE = 2'h3
  } pls_method_type;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_LOAD   = 5'h02,
    ST_SHIFT  = 5'h04,
    ST_STROBE = 5'h08,
    ST_DONE   = 5'h10
  } pls_state_type;

endpackage

// ===== inc/pls_link_if.sv
// interface: serial programming pins between host and synthesizer
`timescale 1ns/1ps
`default_nettype none
interface pls_link_if;
  logic sclk;
  logic sdata;
  logic latch_strobe;
  logic chip_enable;
  logic monitor_output;

  modport host (
    output sclk,
    output sdata,
    output latch_strobe,
    output chip_enable,
    input  monitor_output
  );

  modport dev (
    input  sclk,
    input  sdata,
    input  latch_strobe,
    input  chip_enable,
    output monitor_output
  );
endinterface
`default_nettype wire

// ===== logic/pls_sync2.sv
// module: two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module pls_sync2 (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic d_in,
  output logic      q_out
);
  import pls_pkg::*;

  logic meta_r;
  logic sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule
`default_nettype wire

// ===== logic/pls_device.sv
// module: synthesizer end of the serial load link with start-up control
`timescale 1ns/1ps
`default_nettype none
module pls_device (
  pls_link_if.dev                      link_io,
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic                    lock_indicator_in,
  input  wire logic                    cp_event_in,
  output logic [pls_pkg::WORD_W-1:0]   func_latch_out,
  output logic [pls_pkg::WORD_W-1:0]   ref_latch_out,
  output logic [pls_pkg::WORD_W-1:0]   fb_latch_out,
  output logic                         div_reset_out,
  output logic                         counters_held_out,
  output logic                         cp_tristate_out,
  output logic                         power_down_out,
  output logic                         output_active_out
);
  import pls_pkg::*;

  // ----------------------------------------------------------------
  // serial clock domain
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] shift_r;

  // msb first; older bits fall off the top, so padding is lost
  // the register keeps running whatever the power state
  always_ff @(posedge link_io.sclk or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      shift_r <= LATCH_RST;
    else
      shift_r <= {shift_r[WORD_W-2:0], link_io.sdata};
  end

  // ----------------------------------------------------------------
  // pin synchronisers into the system clock
  // ----------------------------------------------------------------
  logic strobe_s;
  logic ce_s;

  pls_sync2 u_strobe_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .d_in       (link_io.latch_strobe),
    .q_out      (strobe_s)
  );

  pls_sync2 u_ce_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .d_in       (link_io.chip_enable),
    .q_out      (ce_s)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic              strobe_d_r;
  logic              ce_d_r;
  logic [WORD_W-1:0] func_r;
  logic [WORD_W-1:0] ref_r;
  logic [WORD_W-1:0] fb_r;
  logic              armed_r;
  logic              sync_pd_r;
  logic              seen_ref_r;
  logic              seen_fb_r;
  logic              seen_init_r;
  logic              pulse_r;
  logic              held_r;
  logic              cp3s_r;
  logic              pd_r;
  logic              active_r;
  logic              mon_r;

  // ----------------------------------------------------------------
  // load decode
  // ----------------------------------------------------------------
  wire       strobe_rise = strobe_s & ~strobe_d_r;
  wire       ce_rise     = ce_s & ~ce_d_r;
  // the shift register is still while the strobe is high
  wire [1:0] sel         = shift_r[1:0];
  wire       ld_init     = strobe_rise & (sel == SEL_INIT);
  wire       ld_ref      = strobe_rise & (sel == SEL_REF);
  wire       ld_fb       = strobe_rise & (sel == SEL_FB);
  wire       ld_func     = strobe_rise & (sel == SEL_FUNC);

  // ----------------------------------------------------------------
  // control decode from the function latch
  // ----------------------------------------------------------------
  wire       hold_bit    = func_r[HOLD_BIT];
  wire       pd1         = func_r[PD1_BIT];
  wire       pd2         = func_r[PD2_BIT];
  wire [2:0] mon_sel     = func_r[MUX_LSB +: 3];

  // first feedback load after an initialization pulses again
  wire       fb_first    = ld_fb & armed_r;

  // reset pulse sources: init load, first feedback, enable rise
  wire       pulse_nxt   = ld_init | fb_first | ce_rise;

  // synchronous power-down waits for a charge pump event or init
  // the hold bit alone never starts it
  wire       sync_pd_nxt = pd1 & pd2 &
                           (sync_pd_r | cp_event_in | ld_init);

  // low chip enable wins over any programmed power-down bits
  wire       pd_nxt      = ~ce_s | (pd1 & ~pd2) | sync_pd_r;

  // counters held by hold bit, power-down or reset pulse
  wire       held_nxt    = hold_bit | pd_nxt | pulse_nxt;
  wire       cp3s_nxt    = held_nxt | func_r[CP3S_BIT];

  // output comes alive once ref, feedback and init were written and no power-down is pending
  wire       active_nxt  = seen_ref_r & seen_fb_r & seen_init_r &
                           ~pd_nxt;

  // monitor output selection
  wire       mon_nxt     = (mon_sel == MON_LOCK)   ? lock_indicator_in :
                           (mon_sel == MON_HOLD)   ? held_r            :
                           (mon_sel == MON_PD)     ? pd_r              :
                           (mon_sel == MON_ACTIVE) ? active_r          :
                           (mon_sel == MON_HIGH)   ? 1'b1              :
                                                     1'b0;

  // ----------------------------------------------------------------
  // latches: never cleared by chip enable, only by system reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      func_r <= LATCH_RST;
      ref_r  <= LATCH_RST;
      fb_r   <= LATCH_RST;
    end
    else
    begin
      if (ld_func | ld_init)
        func_r <= shift_r;
      if (ld_ref)
        ref_r <= shift_r;
      if (ld_fb)
        fb_r <= shift_r;
    end
  end

  // ----------------------------------------------------------------
  // edge history, arming and first-write tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      strobe_d_r  <= 1'b0;
      ce_d_r      <= 1'b0;
      armed_r     <= 1'b0;
      seen_ref_r  <= 1'b0;
      seen_fb_r   <= 1'b0;
      seen_init_r <= 1'b0;
    end
    else
    begin
      strobe_d_r  <= strobe_s;
      ce_d_r      <= ce_s;
      if (ld_init)
        armed_r <= 1'b1;
      else if (ld_fb)
        armed_r <= 1'b0;
      seen_ref_r  <= seen_ref_r | ld_ref;
      seen_fb_r   <= seen_fb_r | ld_fb;
      seen_init_r <= seen_init_r | ld_init;
    end
  end

  // ----------------------------------------------------------------
  // power and counter control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sync_pd_r <= 1'b0;
      pulse_r   <= 1'b0;
      held_r    <= 1'b1;
      cp3s_r    <= 1'b1;
      pd_r      <= 1'b1;
      active_r  <= 1'b0;
      mon_r     <= 1'b0;
    end
    else
    begin
      sync_pd_r <= sync_pd_nxt;
      pulse_r   <= pulse_nxt;
      held_r    <= held_nxt;
      cp3s_r    <= cp3s_nxt;
      pd_r      <= pd_nxt;
      active_r  <= active_nxt;
      mon_r     <= mon_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign func_latch_out         = func_r;
  assign ref_latch_out          = ref_r;
  assign fb_latch_out           = fb_r;
  assign div_reset_out          = pulse_r;
  assign counters_held_out      = held_r;
  assign cp_tristate_out        = cp3s_r;
  assign power_down_out         = pd_r;
  assign output_active_out      = active_r;
  assign link_io.monitor_output = mon_r;
endmodule
`default_nettype wire

// ===== test/pls_link_assertions.sv
// checker: wire-level properties of the serial load link
`timescale 1ns/1ps
`default_nettype none
module pls_link_assertions (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic latch_strobe
);
  logic       sclk_d_r;
  logic [4:0] bit_cnt_r;
  logic [4:0] bit_cnt_nxt;
  logic       sclk_rise;

  // ------------------------------------------------------------
  // count serial clock rises since the strobe went low
  // ------------------------------------------------------------
  assign sclk_rise   = sclk & ~sclk_d_r;
  assign bit_cnt_nxt = latch_strobe ? 5'h00 : bit_cnt_r + {4'h0, sclk_rise};

  // registered copy of the serial clock and the bit count
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sclk_d_r  <= 1'b0;
      bit_cnt_r <= 5'h00;
    end
    else
    begin
      sclk_d_r  <= sclk;
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_no_sclk_strobe: assert property (latch_strobe |-> !sclk)
    else $error("serial clock high while strobe high");
  a_strobe_width: assert property ($rose(latch_strobe) |-> latch_strobe[*4])
    else $error("strobe pulse too short");
  a_sclk_rate: assert property ($rose(sclk) |=> $fell(sclk))
    else $error("serial clock high longer than one cycle");
  a_bit_cadence: assert property ($rose(sclk) |-> ##1 !sclk ##1
    (sclk || bit_cnt_r == 5'h18))
    else $error("gap inside a word");
  a_bit_count: assert property ($rose(latch_strobe) |-> bit_cnt_r == 5'h18)
    else $error("strobe after wrong bit count");
  a_count_limit: assert property (sclk_rise |-> bit_cnt_r < 5'h18)
    else $error("more than 24 bits in a word");
  a_pad_zero: assert property (sclk_rise && bit_cnt_r < 5'h03 |-> !sdata)
    else $error("padding bit not zero");
  a_data_steady: assert property (sclk |-> $stable(sdata))
    else $error("data moved while serial clock high");
endmodule
`default_nettype wire

// ===== test/tb.sv
// testbench: host and device joined, programming methods checked
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pls_pkg::*;
  logic           clk_in = 1'b0;
  logic           sys_rst_in = 1'b1;
  logic           start = 1'b0;
  pls_method_type method = METH_SINGLE;
  logic [20:0]    func_word = 21'h0;
  logic [20:0]    ref_word = 21'h0;
  logic [20:0]    fb_word = 21'h0;
  logic           ce = 1'b1;
  logic           lock = 1'b0;
  logic           done, busy, mon, dreset, held, cp3s, pd, active;
  logic           cp_ev = 1'b0;
  logic [20:0]    func_l, ref_l, fb_l, f, r, b, w;
  logic [31:0]    seed = 32'h998f;
  logic [2:0]     codes [6] = '{MON_LOW, MON_LOCK, MON_HOLD, MON_PD,
                                MON_ACTIVE, MON_HIGH};
  int             failures = 0;
  int             check_count = 0;
  int             pulses = 0;

  pls_link_if link ();
  pls_host pls_host_inst (.link_io(link), .clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .start_in(start), .method_in(method),
    .func_word_in(func_word), .ref_word_in(ref_word),
    .fb_word_in(fb_word), .ce_in(ce), .busy_out(busy), .done_out(done),
    .monitor_out(mon));
  pls_device pls_device_inst (.link_io(link), .clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .lock_indicator_in(lock), .cp_event_in(cp_ev),
    .func_latch_out(func_l), .ref_latch_out(ref_l), .fb_latch_out(fb_l),
    .div_reset_out(dreset), .counters_held_out(held),
    .cp_tristate_out(cp3s), .power_down_out(pd),
    .output_active_out(active));
  pls_link_assertions pls_link_assertions_inst (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .sclk(link.sclk), .sdata(link.sdata),
    .latch_strobe(link.latch_strobe));

  // clock and counter reset pulse count
  always #20 clk_in = ~clk_in;
  // pulses are counted mid-cycle, where the output has settled
  always @(negedge clk_in)
    if (dreset === 1'b1) pulses++;

  // xorshift source of random words
  function logic [20:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[20:0];
  endfunction

  // expected monitor level with nothing held or powered down
  function logic mexp(input logic [2:0] c, input logic lk);
    case (c)
      MON_LOCK: return lk;
      MON_ACTIVE, MON_HIGH: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  task chk(input string what, input logic [20:0] seen, input logic [20:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask

  task go(input pls_method_type m);
    @(negedge clk_in);
    method = m;
    start = 1'b1;
    pulses = 0;
    @(negedge clk_in);
    start = 1'b0;
    chk("busy", 21'(busy), 21'h1);
  endtask

  task finish_op();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 500)
    begin
      @(negedge clk_in);
      n++;
    end
    if (n == 500) failures++;
    repeat (8) @(negedge clk_in);
    chk("busy", 21'(busy), 21'h0);
  endtask

  task single(input logic [20:0] word);
    func_word = word;
    go(METH_SINGLE);
    finish_op();
  endtask

  task complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial
  begin
    repeat (6000) @(posedge clk_in);
    failures++;
    complete_run();
  end

  // main sequence
  initial
  begin
    repeat (16) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("active", 21'(active), 21'h0);
    chk("func", func_l, LATCH_RST);
    repeat (6) @(negedge clk_in);
    chk("pulses", pulses[20:0], 21'h1);
    f = rnd() & 21'h1ffe07;
    r = rnd();
    b = rnd();
    func_word = f;
    ref_word = r;
    fb_word = b;
    go(METH_INIT);
    finish_op();
    chk("func", func_l, {f[20:3], 1'b0, SEL_INIT});
    chk("ref", ref_l, {r[20:2], SEL_REF});
    chk("fb", fb_l, {b[20:2], SEL_FB});
    chk("pulses", pulses[20:0], 21'h2);
    chk("active", 21'(active), 21'h1);
    $display("test init done");
    w = rnd();
    b = {w[20:2], SEL_FB};
    single(b);
    chk("fb", fb_l, b);
    chk("pulses", pulses[20:0], 21'h0);
    single(b);
    chk("fb", fb_l, b);
    chk("pulses", pulses[20:0], 21'h0);
    $display("test feedback done");
    f = (rnd() & 21'h1ffe00) | 21'h6;
    single(f);
    chk("func", func_l, f);
    chk("held", 21'(held), 21'h1);
    chk("tristate", 21'(cp3s), 21'h1);
    chk("pd", 21'(pd), 21'h0);
    r = rnd();
    b = rnd();
    ref_word = r;
    fb_word = b;
    go(METH_HOLD);
    finish_op();
    chk("func", func_l, {f[20:3], 1'b0, SEL_FUNC});
    chk("held", 21'(held), 21'h0);
    chk("pulses", pulses[20:0], 21'h0);
    chk("fb", fb_l, {b[20:2], SEL_FB});
    $display("test hold done");
    f = rnd() & 21'h1ffe03;
    r = rnd();
    b = rnd();
    func_word = f;
    ref_word = r;
    fb_word = b;
    go(METH_PIN);
    repeat (20) @(negedge clk_in);
    chk("pd", 21'(pd), 21'h1);
    finish_op();
    chk("func", func_l, {f[20:2], SEL_FUNC});
    chk("ref", ref_l, {r[20:2], SEL_REF});
    chk("fb", fb_l, {b[20:2], SEL_FB});
    chk("pulses", pulses[20:0], 21'h1);
    chk("pd", 21'(pd), 21'h0);
    $display("test pin done");
    ce = 1'b0;
    repeat (6) @(negedge clk_in);
    chk("pd", 21'(pd), 21'h1);
    w = rnd();
    w = {w[20:2], SEL_REF};
    single(w);
    chk("ref", ref_l, w);
    ce = 1'b1;
    repeat (8) @(negedge clk_in);
    chk("pd", 21'(pd), 21'h0);
    chk("func", func_l, {f[20:2], SEL_FUNC});
    chk("fb", fb_l, {b[20:2], SEL_FB});
    $display("test enable done");
    w = (rnd() & 21'h1ffe03) | 21'h3;
    single(w);
    chk("func", func_l, w);
    chk("pulses", pulses[20:0], 21'h1);
    w = rnd();
    b = {w[20:2], SEL_FB};
    single(b);
    chk("pulses", pulses[20:0], 21'h1);
    single(b ^ 21'h100004);
    chk("pulses", pulses[20:0], 21'h0);
    $display("test rearm done");
    for (int i = 0; i < 6; i++)
    begin
      lock = seed[3];
      w = rnd();
      single({w[20:7], codes[i], 4'h2});
      chk("monitor", 21'(mon), 21'(mexp(codes[i], lock)));
    end
    $display("test monitor done");
    // synchronous power-down waits for a charge pump event
    w = rnd();
    f = {w[20], 1'b1, w[18:9], 9'h00e};
    single(f);
    chk("pd", 21'(pd), 21'h0);
    cp_ev = 1'b1;
    @(negedge clk_in);
    cp_ev = 1'b0;
    repeat (4) @(negedge clk_in);
    chk("pd", 21'(pd), 21'h1);
    single(21'h000002);
    chk("pd", 21'(pd), 21'h0);
    chk("held", 21'(held), 21'h0);
    $display("test sync power-down done");
    complete_run();
  end
endmodule
`default_nettype wire
